// File: margin_watchdog_defines.svh
/*
  Constants of the margining and supervision-timer command decoder: bus
  address, operation codes, timer periods and clock rates.
  Assumes a single 100 MHz system clock.
*/
`ifndef MARGIN_WATCHDOG_DEFINES_SVH
`define MARGIN_WATCHDOG_DEFINES_SVH

`define ADDR_FIXED      5'h1D
`define OP_MARGIN       3'h1
`define OP_WATCHDOG     3'h3
`define VALUE_ZERO      5'h00
`define MARGIN_UNUSED   4'hF
`define MARGIN_NOMINAL  4'h0
`define TIMER_PREFIX    2'h1
`define TIMER_PER_00_MS 11'h500
`define TIMER_PER_01_MS 11'h140
`define TIMER_PER_10_MS 11'h050
`define TIMER_PER_11_MS 11'h014
`define CLK_PERIOD_NS   10
`define MS_IN_NS        1000000
`define TICK_CYCLES     (`MS_IN_NS / `CLK_PERIOD_NS)

`endif

// File: margin_watchdog_pkg.sv
/*
  Types of the margining and supervision-timer command decoder.
  Assumes the constants header is on the include path.
*/
`include "margin_watchdog_defines.svh"

package margin_watchdog_pkg;

  typedef enum logic [5:0] {
    S_IDLE     = 6'h01,
    S_ADDR     = 6'h02,
    S_ADDR_ACK = 6'h04,
    S_DATA     = 6'h08,
    S_DATA_ACK = 6'h10,
    S_IGNORE   = 6'h20
  } bus_state_t;

  typedef enum logic [2:0] {
    ARM_NONE   = 3'h1,
    ARM_MARGIN = 3'h2,
    ARM_TIMER  = 3'h4
  } arm_t;

  typedef struct packed {
    logic [3:0] linear_output;
    logic [3:0] switching_output;
  } margin_codes_t;

  typedef struct packed {
    logic       scl1;
    logic       scl2;
    logic       scl3;
    logic       sda1;
    logic       sda2;
    logic       sda3;
    logic [1:0] straps1;
    logic [1:0] straps2;
    bus_state_t fsm;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       ack_drive;
    arm_t       armed;
    margin_codes_t margin;
    logic       timer_on;
    logic       timer_window;
    logic [1:0] timer_period;
    logic [16:0] tick_cnt;
    logic [10:0] ms_cnt;
    logic       timer_expired;
  } state_t;

endpackage

// File: margin_watchdog_cmd_decoder.sv
/*
  Write-only two-wire slave that decodes armed command bytes into output
  margining codes and programs a windowed supervision timer.
  Assumes scl_in and sda_in come from pins (synchronised here), the straps
  are static, and the pad resolves sda from sda_oe with an external pull-up.
*/
`timescale 1ns/1ps
`include "margin_watchdog_defines.svh"

module margin_watchdog_cmd_decoder
  import margin_watchdog_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          rst,
  // Two-wire bus pins.
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  // Address straps.
  input  wire logic          clock_mode_strap,
  input  wire logic          slave_id_bit_low,
  // Margining codes.
  output margin_codes_t      margin,
  // Supervision timer state.
  output logic               supervision_timer_on,
  output logic               supervision_timer_window,
  output logic [1:0]         supervision_timer_period,
  output logic               supervision_timer_expired
);

  state_t      st;
  state_t      next_st;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        exec;
  logic [2:0]  op;
  logic [4:0]  val;
  logic [10:0] per_ms;
  logic        win_open;
  logic [6:0]  own_addr;

  function automatic logic [10:0] period_ms(input logic [1:0] pp);
    case (pp)
      2'h0:    period_ms = `TIMER_PER_00_MS;
      2'h1:    period_ms = `TIMER_PER_01_MS;
      2'h2:    period_ms = `TIMER_PER_10_MS;
      default: period_ms = `TIMER_PER_11_MS;
    endcase
  endfunction

  // Edges are found on the second and third stages only.
  assign scl_rise  = st.scl2 & ~st.scl3;
  assign scl_fall  = ~st.scl2 & st.scl3;
  assign start_det = st.scl2 & st.scl3 & ~st.sda2 & st.sda3;
  assign stop_det  = st.scl2 & st.scl3 & st.sda2 & ~st.sda3;
  assign op        = st.shift[7:5];
  assign val       = st.shift[4:0];
  assign per_ms    = period_ms(st.timer_period);
  assign win_open  = st.ms_cnt >= (per_ms >> 1);
  assign own_addr  = {`ADDR_FIXED, st.straps2};
  // each data byte is executed at the falling edge of its own eighth clock
  assign exec      = scl_fall && st.fsm == S_DATA && st.bit_cnt == 4'h8;

  always_comb begin
    next_st = st;
    next_st.scl1 = scl_in;
    next_st.scl2 = st.scl1;
    next_st.scl3 = st.scl2;
    next_st.sda1 = sda_in;
    next_st.sda2 = st.sda1;
    next_st.sda3 = st.sda2;
    next_st.straps1 = {clock_mode_strap, slave_id_bit_low};
    next_st.straps2 = st.straps1;
    next_st.timer_expired = 1'b0;

    // The timer counts whole milliseconds from a cycle prescaler.
    if (st.timer_on) begin
      if (st.tick_cnt == 17'(TICK_CYCLES - 1)) begin
        next_st.tick_cnt = 17'h00000;
        if (st.ms_cnt == per_ms - 11'h001) begin
          next_st.ms_cnt = 11'h000;
          next_st.timer_expired = 1'b1;
        end else begin
          next_st.ms_cnt = st.ms_cnt + 11'h001;
        end
      end else begin
        next_st.tick_cnt = st.tick_cnt + 17'h00001;
      end
    end

    if (start_det) begin
      next_st.fsm = S_ADDR;
      next_st.bit_cnt = 4'h0;
      next_st.armed = ARM_NONE;
      next_st.ack_drive = 1'b0;
    end else if (stop_det) begin
      next_st.fsm = S_IDLE;
      next_st.armed = ARM_NONE;
      next_st.ack_drive = 1'b0;
    end else if (scl_rise && (st.fsm == S_ADDR || st.fsm == S_DATA)) begin
      next_st.shift = {st.shift[6:0], st.sda2};
      next_st.bit_cnt = st.bit_cnt + 4'h1;
    end else if (scl_fall) begin
      case (st.fsm)
        S_ADDR: begin
          if (st.bit_cnt == 4'h8) begin
            if (st.shift == {own_addr, 1'b0}) begin
              next_st.fsm = S_ADDR_ACK;
              next_st.ack_drive = 1'b1;
            end else begin
              next_st.fsm = S_IGNORE;
            end
          end
        end
        S_ADDR_ACK, S_DATA_ACK: begin
          next_st.fsm = S_DATA;
          next_st.bit_cnt = 4'h0;
          next_st.ack_drive = 1'b0;
        end
        S_DATA: begin
          if (st.bit_cnt == 4'h8) begin
            next_st.fsm = S_DATA_ACK;
            next_st.ack_drive = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (exec) begin
      // arming byte has a zero value field
      if (val == `VALUE_ZERO && (op == `OP_MARGIN || op == `OP_WATCHDOG)) begin
        if (op == `OP_WATCHDOG && st.armed == ARM_TIMER) begin
          // second timer arming byte stops timer
          next_st.timer_on = 1'b0;
          next_st.tick_cnt = 17'h00000;
          next_st.ms_cnt = 11'h000;
          next_st.armed = ARM_NONE;
        end else begin
          // operation code selects the armed operation
          next_st.armed = (op == `OP_MARGIN) ? ARM_MARGIN : ARM_TIMER;
        end
      end else if (st.armed == ARM_MARGIN && op == `OP_MARGIN &&
                   val[3:0] != `MARGIN_UNUSED) begin
        // bit 4 selects output; low bits give offset code
        // margining stays armed for a second output byte
        if (val[4]) begin
          next_st.margin.switching_output = val[3:0];
        end else begin
          next_st.margin.linear_output = val[3:0];
        end
      end else if (st.armed == ARM_TIMER && op == `OP_WATCHDOG &&
                   val[4:3] == `TIMER_PREFIX) begin
        // start timer; clear and reload together
        // windowed mode only accepts inside open window
        if (!st.timer_on || !st.timer_window || win_open) begin
          next_st.timer_on = 1'b1;
          next_st.timer_window = val[2];
          next_st.timer_period = val[1:0];
          next_st.tick_cnt = 17'h00000;
          next_st.ms_cnt = 11'h000;
        end
        next_st.armed = ARM_NONE;
      end else begin
        // mismatched or undefined bytes drop the arming
        next_st.armed = ARM_NONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.scl1 <= 1'b1;
      st.scl2 <= 1'b1;
      st.scl3 <= 1'b1;
      st.sda1 <= 1'b1;
      st.sda2 <= 1'b1;
      st.sda3 <= 1'b1;
      st.fsm <= S_IDLE;
      st.armed <= ARM_NONE;
      st.margin <= {`MARGIN_NOMINAL, `MARGIN_NOMINAL};
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = st.ack_drive;
  assign margin = st.margin;
  assign supervision_timer_on = st.timer_on;
  assign supervision_timer_window = st.timer_window;
  assign supervision_timer_period = st.timer_period;
  assign supervision_timer_expired = st.timer_expired;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_timer_armed_exec;
    exec && st.armed == ARM_TIMER;
  endsequence

  sequence s_timer_prog_ok;
    s_timer_armed_exec ##0 op == `OP_WATCHDOG &&
      val[4:3] == `TIMER_PREFIX
      ##0 (!st.timer_on || !st.timer_window || win_open);
  endsequence

  a_ack_only_acks: assert property (
    sda_oe |-> (st.fsm == S_ADDR_ACK || st.fsm == S_DATA_ACK))
    else $error("sda driven outside an acknowledge slot");

  a_addr_match_ack: assert property (
    (scl_fall && st.fsm == S_ADDR && st.bit_cnt == 4'h8 && !start_det &&
     !stop_det && st.shift == {own_addr, 1'b0}) |=> sda_oe)
    else $error("own address not acknowledged");

  a_margin_linear: assert property (
    (exec && st.armed == ARM_MARGIN && op == `OP_MARGIN && !val[4] &&
     val != `VALUE_ZERO && val[3:0] != `MARGIN_UNUSED)
    |=> margin.linear_output == $past(val[3:0]) ##1 $stable(margin))
    else $error("linear margin code not applied");

  a_margin_switch: assert property (
    (exec && st.armed == ARM_MARGIN && op == `OP_MARGIN && val[4] &&
     val[3:0] != `MARGIN_UNUSED)
    |=> margin.switching_output == $past(val[3:0]) && st.armed == ARM_MARGIN)
    else $error("switching margin code not applied");

  a_unarmed_ignore: assert property (
    (exec && st.armed == ARM_NONE) |=> $stable(margin) &&
      $stable(supervision_timer_window) && $stable(supervision_timer_period))
    else $error("unarmed command changed state");

  a_timer_double_off: assert property (
    (s_timer_armed_exec ##0 st.shift == {`OP_WATCHDOG, `VALUE_ZERO})
    |=> !supervision_timer_on ##1 !supervision_timer_on)
    else $error("double arming did not stop the timer");

  a_timer_program: assert property (
    s_timer_prog_ok |=> supervision_timer_on && st.ms_cnt == 11'h000 &&
      supervision_timer_period == $past(val[1:0]))
    else $error("timer not cleared and reloaded");

  a_timer_window_shut: assert property (
    (s_timer_armed_exec ##0 st.timer_on && st.timer_window && !win_open &&
     op == `OP_WATCHDOG) |=> $stable(supervision_timer_period) &&
      supervision_timer_window)
    else $error("timer reprogrammed while window closed");

  a_stop_idle: assert property (
    stop_det |=> st.fsm == S_IDLE && st.armed == ARM_NONE && !sda_oe)
    else $error("stop did not return to idle");

  a_reset_state: assert property (
    $past(rst) |-> margin == 8'h00 && !supervision_timer_on)
    else $error("reset state not nominal");

endmodule

// File: i2c_host_model.sv
/*
  Bus master model that writes bytes to the slave at a 125 ns bit period.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps

module i2c_host_model (
  // Bus lines.
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  localparam realtime Q = 31.25;

  // The bus clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start();
    sda_drv = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic clk_bit(input logic v, output logic s);
    sda_drv = v;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, ack);
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b1;
    #(2 * Q);
  endtask
endmodule

// File: margin_watchdog_cmd_decoder_tb_top.sv
/*
  Self-checking bench of the command decoder, with a bus master model.
  Assumes the constants header and package are compiled first.
*/
`timescale 1ns/1ps
`include "margin_watchdog_defines.svh"

module margin_watchdog_cmd_decoder_tb_top
  import margin_watchdog_pkg::*;
;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic          scl, sda_drv, sda_out, sda_oe, strap1, strap0;
  logic          t_on, t_win, t_exp;
  logic [1:0]    t_per;
  wire logic     sda_line;
  margin_codes_t margin;
  wire [11:0]    obs = {margin, t_on, t_win, t_per};
  int            err_total = 0;
  int            comparisons = 0;
  logic [11:0]   exp_q[$];
  logic [11:0]   exp_last = 12'h000;
  logic [11:0]   seen = 12'h000;
  logic [7:0]    b[$];
  logic [6:0]    good;

  always #5 mclk = ~mclk;
  assign sda_line = sda_drv & (sda_out | ~sda_oe);

  i2c_host_model i2c_host_model_i (
    .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  margin_watchdog_cmd_decoder #(.TICK_CYCLES(100))
    margin_watchdog_cmd_decoder_i (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .clock_mode_strap(strap1),
    .slave_id_bit_low(strap0), .margin(margin),
    .supervision_timer_on(t_on), .supervision_timer_window(t_win),
    .supervision_timer_period(t_per), .supervision_timer_expired(t_exp));

  task automatic end_sim();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_obs(input logic [11:0] g, input logic [11:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_obs({11'h000, g}, {11'h000, e});
  endtask

  task automatic note(input logic [11:0] v);
    if (v !== exp_last) begin
      exp_q.push_back(v);
      exp_last = v;
    end
  endtask

  task automatic nt(input logic on, input logic w, input logic [1:0] p);
    note({exp_last[11:4], on, w, p});
  endtask

  task automatic xfer(input logic [6:0] adr, input logic rw);
    logic a;
    logic hit;
    logic [1:0] r;
    hit = (adr === good) && !rw;
    i2c_host_model_i.start();
    i2c_host_model_i.put_byte({adr, rw}, a);
    chk_bit(a, ~hit);
    foreach (b[i]) if (hit) begin
      i2c_host_model_i.put_byte(b[i], a);
      chk_bit(a, 1'b0);
    end
    i2c_host_model_i.stop();
    b.delete();
    repeat (10) @(posedge mclk);
    chk_bit(exp_q.size() == 0, 1'b1);
    exp_q.delete();
    // New straps are applied while the bus is idle.
    r = 2'($urandom());
    {strap1, strap0} <= r;
    good = {`ADDR_FIXED, r};
  endtask

  // Every change of the outputs must match the oldest note.
  always @(posedge mclk) begin
    if (!rst && obs !== seen) begin
      if (exp_q.size() == 0)
        chk_obs(obs, seen);
      else
        chk_obs(obs, exp_q.pop_front());
      seen = obs;
    end
  end

  initial begin
    int c;
    c = $urandom(32'h96fd);
    @(posedge mclk);
    {strap1, strap0} <= 2'(c);
    good = {`ADDR_FIXED, 2'(c)};
    repeat (19) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_obs(obs, 12'h000);
    chk_bit(sda_oe, 1'b0);
    $display("test reset done");
    b = '{8'h20, 8'h25};
    xfer(good ^ 7'h02, 1'b0);
    b = '{8'h20, 8'h25};
    xfer(good ^ 7'h01, 1'b0);
    b = '{8'h20, 8'h25};
    xfer(good, 1'b1);
    b = '{8'h25};
    xfer(good, 1'b0);
    b = '{8'h60, 8'h25};
    xfer(good, 1'b0);
    $display("test address done");
    b = '{8'h20};
    for (int v = 0; v < 15; v++) begin
      b.push_back({`OP_MARGIN, 1'b0, v[3:0]});
      b.push_back({`OP_MARGIN, 1'b1, 4'(14 - v)});
      note({v[3:0], exp_last[7:0]});
      note({exp_last[11:8], 4'(14 - v), exp_last[3:0]});
    end
    b.push_back(8'h2F);
    b.push_back(8'h65);
    b.push_back(8'h25);
    xfer(good, 1'b0);
    $display("test margin done");
    for (int p = 0; p < 4; p++) begin
      b.push_back(8'h60);
      b.push_back({`OP_WATCHDOG, `TIMER_PREFIX, 1'b0, p[1:0]});
      nt(1'b1, 1'b0, p[1:0]);
    end
    b.push_back(8'h60);
    b.push_back(8'h6F);
    nt(1'b1, 1'b1, 2'h3);
    b.push_back(8'h60);
    b.push_back(8'h60);
    nt(1'b0, 1'b1, 2'h3);
    xfer(good, 1'b0);
    b = '{8'h60, 8'h6B};
    nt(1'b1, 1'b0, 2'h3);
    xfer(good, 1'b0);
    c = 0;
    while (!t_exp && c < 3000) begin
      @(posedge mclk);
      c++;
    end
    chk_bit(c > 1900 && c < 2010, 1'b1);
    $display("test timer done");
    b = '{8'h60, 8'h6F};
    nt(1'b1, 1'b1, 2'h3);
    xfer(good, 1'b0);
    b = '{8'h60, 8'h6C};
    xfer(good, 1'b0);
    repeat (700) @(posedge mclk);
    b = '{8'h60, 8'h6C};
    nt(1'b1, 1'b1, 2'h0);
    xfer(good, 1'b0);
    b = '{8'h20};
    xfer(good, 1'b0);
    b = '{8'h21};
    xfer(good, 1'b0);
    $display("test window done");
    note(12'h000);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_bit(exp_q.size() == 0, 1'b1);
    chk_obs(obs, 12'h000);
    chk_bit(sda_oe, 1'b0);
    $display("test reset again done");
    end_sim();
  end
endmodule
